// ### core/drs_ramp.sv
`timescale 1ns/100ps
// one mV per period toward the target
module drs_ramp #(
    parameter int W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] target_i,
    input wire logic [7:0] period_i,
    output logic [W-1:0] ref_o,
    output logic at_target_o
);
    logic [7:0] cnt_r;

    assign at_target_o = (ref_o == target_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 8'h00;
            ref_o <= '0;
        end else if (at_target_o) begin
            cnt_r <= 8'h00;
        end else if (cnt_r >= period_i - 8'h01) begin
            cnt_r <= 8'h00;
            ref_o <= (ref_o < target_i) ? ref_o + 1'b1 : ref_o - 1'b1;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule

// ### core/drs_seq.sv
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
// Overview of operation
// - power ready needs controller supply and driver supply comparators both above threshold.
// - power ready plus enable high starts soft-start on both rails together; code needs an enable rise after power ready, with platform ok low.
// - losing controller supply or driver supply enters power-down, disabling everything.
// - voltage-code interface ready no later than 2 ms after enable.
// - protection latches clear only on power ready low, not on enable low.
// - enable rising edge latches clock and line pins as boot code.
// - both rails soft-start in continuous conduction at 3 mV/us toward boot code.
// - power good after delay when outputs exceed boot minus 300 mV.
// - telemetry line held high until the serial interface runs.
// - platform ok high starts the serial interface, awaiting commands.
// - valid command starts fly change; completion reported at target.
// - platform ok low stops interface, outputs return to boot code.
// - enable loss drops both goods at once and starts soft-shutdown.
// - soft-shutdown ramps down at soft-start slew, continuous conduction kept.
// - each rail stops switching once its sense falls through about 0.2 V.
// - boot code cleared at power ready reset, resampled next enable.
// - goods low while enable low and soft-start; released independently.
// - a rail's good drops on overvoltage, undervoltage, overcurrent or enable low.
// - one rail's protection pulls the other rail's good low 5 us later.
// - platform ok falling drives telemetry high while restoring boot code.
// - serial inputs ignored after platform ok loss until it returns.
module drs_seq #(
    parameter int PG_CYC = drs_pkg::PG_DELAY_CYC,
    parameter int SVI_CYC = drs_pkg::SVI_READY_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ctrl_supply_ok_i,
    input wire logic driver_supply_ok_i,
    input wire logic enable_hi_i,
    input wire drs_pkg::drs_rail_t core_rail_i,
    input wire drs_pkg::drs_rail_t nb_rail_i,
    input wire logic platform_ok_i,
    input wire logic serial_vid_clock_i,
    input wire logic serial_vid_line_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_core_i,
    input wire logic cmd_nb_i,
    input wire logic [11:0] cmd_target_mv_i,
    input wire logic telem_data_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [11:0] core_ref_o,
    output logic [11:0] nb_ref_o,
    output logic core_switch_o,
    output logic nb_switch_o,
    output logic core_good_o,
    output logic nb_good_o,
    output logic ccm_o,
    output logic svi_run_o,
    output logic telemetry_line_o,
    output logic vid_fly_change_done_o,
    output logic [11:0] pg_thresh_mv_o
);
    // ****************************************
    // synchronised comparators
    // ****************************************
    logic [2:0] sup_s;
    drs_pkg::drs_rail_t core_s, nb_s;
    logic power_ready, en_eff, en_d_r, en_rise;
    logic ctrl_en_r;
    drs_pkg::drs_state_t st_r;
    logic [11:0] ref_w [2];
    drs_sync #(.W(3)) u_sync_sup (.clk_i(clk_i), .rst_i(rst_i),
        .d_i({ctrl_supply_ok_i, driver_supply_ok_i, enable_hi_i}), .q_o(sup_s));
    drs_sync #(.W(10)) u_sync_rail (.clk_i(clk_i), .rst_i(rst_i),
        .d_i({core_rail_i, nb_rail_i}), .q_o({core_s, nb_s}));
    assign power_ready = sup_s[2] & sup_s[1];
    assign en_eff = sup_s[0] & ctrl_en_r;
    assign en_rise = en_eff & ~en_d_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_d_r <= 1'b0;
        end else begin
            en_d_r <= en_eff;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    logic [1:0] boot_code_r, boot_pins;
    logic boot_valid_r, order_err_r, start_ok;
    logic [1:0] at_tgt, switch_r;
    drs_pkg::drs_rail_t rail_s [2];
    assign rail_s[0] = core_s;
    assign rail_s[1] = nb_s;
    assign boot_pins = {serial_vid_clock_i, serial_vid_line_i};
    // platform ok already high at enable means wrong order: no start
    assign start_ok = en_rise & ~platform_ok_i;
    always_ff @(posedge clk_i) begin
        if (rst_i || !power_ready) begin
            st_r <= drs_pkg::ST_OFF;
        end else begin
            unique case (st_r)
                drs_pkg::ST_OFF: st_r <= drs_pkg::ST_WAIT_EN;
                drs_pkg::ST_WAIT_EN: begin
                    if (start_ok) begin
                        st_r <= drs_pkg::ST_SOFT;
                    end
                end
                drs_pkg::ST_SOFT: begin
                    if (!en_eff) begin
                        st_r <= drs_pkg::ST_SHUT;
                    end else if (ref_w[0] == drs_pkg::boot_mv(boot_code_r)
                            && ref_w[1] == drs_pkg::boot_mv(boot_code_r)) begin
                        // targets are still zero on entry: wait for the boot level itself
                        st_r <= drs_pkg::ST_RUN;
                    end
                end
                drs_pkg::ST_RUN: begin
                    if (!en_eff) begin
                        st_r <= drs_pkg::ST_SHUT;
                    end
                end
                drs_pkg::ST_SHUT: begin
                    if (switch_r == 2'b00) begin
                        st_r <= drs_pkg::ST_WAIT_EN;
                    end
                end
                default: st_r <= drs_pkg::ST_OFF;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || !power_ready) begin
            boot_code_r <= 2'h0;
            boot_valid_r <= 1'b0;
            order_err_r <= 1'b0;
        end else if (st_r == drs_pkg::ST_WAIT_EN && en_rise) begin
            order_err_r <= platform_ok_i;
            if (!platform_ok_i) begin
                boot_code_r <= boot_pins;
                boot_valid_r <= 1'b1;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_i || st_r == drs_pkg::ST_OFF || st_r == drs_pkg::ST_WAIT_EN) begin
                switch_r[i] <= 1'b0;
            end else if (st_r == drs_pkg::ST_SOFT) begin
                switch_r[i] <= 1'b1;
            end else if (st_r == drs_pkg::ST_SHUT && rail_s[i].below_off) begin
                switch_r[i] <= 1'b0;
            end
        end
    end

    // ****************************************
    // serial interface gating
    // ****************************************
    localparam int SVW = $clog2(SVI_CYC + 1);
    logic [SVW-1:0] svi_cnt_r;
    logic svi_ready_r, svi_run_r, pok_d_r, pok_fall, cmd_acc;
    assign pok_fall = pok_d_r & ~platform_ok_i;
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_eff || st_r == drs_pkg::ST_WAIT_EN || st_r == drs_pkg::ST_OFF) begin
            svi_cnt_r <= '0;
            svi_ready_r <= 1'b0;
        end else if (svi_cnt_r == SVW'(SVI_CYC - 1)) begin
            svi_ready_r <= 1'b1;
        end else begin
            svi_cnt_r <= svi_cnt_r + 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pok_d_r <= 1'b0;
            svi_run_r <= 1'b0;
        end else begin
            pok_d_r <= platform_ok_i;
            svi_run_r <= svi_ready_r & platform_ok_i & en_eff & ~order_err_r;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            telemetry_line_o <= 1'b1;
        end else if (svi_run_r && platform_ok_i) begin
            telemetry_line_o <= telem_data_i;
        end else begin
            telemetry_line_o <= 1'b1;
        end
    end
    // commands only while the interface runs
    assign cmd_acc = cmd_valid_i & svi_run_r & platform_ok_i & (st_r == drs_pkg::ST_RUN);

    // ****************************************
    // reference targets and ramps
    // ****************************************
    logic [11:0] target_r [2];
    logic slow_r, vid_fly_change_pend_r;
    logic [7:0] period;
    assign period = slow_r ? 8'(drs_pkg::SS_STEP_CYC) : 8'(drs_pkg::VID_FLY_CHANGE_STEP_CYC);
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_i) begin
                target_r[i] <= 12'h000;
            end else begin
                unique case (st_r)
                    drs_pkg::ST_SOFT: target_r[i] <= drs_pkg::boot_mv(boot_code_r);
                    drs_pkg::ST_RUN: begin
                        if (!en_eff) begin
                            target_r[i] <= 12'h000;
                        end else if (pok_fall) begin
                            target_r[i] <= drs_pkg::boot_mv(boot_code_r);
                        end else if (cmd_acc && (i == 0 ? cmd_core_i : cmd_nb_i)) begin
                            target_r[i] <= cmd_target_mv_i;
                        end
                    end
                    default: target_r[i] <= 12'h000;
                endcase
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_r <= 1'b1;
        end else begin
            slow_r <= (st_r != drs_pkg::ST_RUN) | ~en_eff;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || st_r != drs_pkg::ST_RUN) begin
            vid_fly_change_pend_r <= 1'b0;
            vid_fly_change_done_o <= 1'b0;
        end else if (cmd_acc) begin
            vid_fly_change_pend_r <= 1'b1;
            vid_fly_change_done_o <= 1'b0;
        end else begin
            vid_fly_change_done_o <= vid_fly_change_pend_r & (&at_tgt) & svi_run_r;
            if (&at_tgt) begin
                vid_fly_change_pend_r <= 1'b0;
            end
        end
    end
    drs_ramp u_ramp_core (.clk_i(clk_i), .rst_i(rst_i), .target_i(target_r[0]), .period_i(period),
        .ref_o(ref_w[0]), .at_target_o(at_tgt[0]));
    drs_ramp u_ramp_nb (.clk_i(clk_i), .rst_i(rst_i), .target_i(target_r[1]), .period_i(period),
        .ref_o(ref_w[1]), .at_target_o(at_tgt[1]));

    // ****************************************
    // protection and power good
    // ****************************************
    localparam int PGW = $clog2(PG_CYC + 1);
    localparam int CRW = $clog2(drs_pkg::CROSS_DELAY_CYC + 1);
    logic [1:0] fault_r, cross_r, good_r, kill;
    logic [PGW-1:0] pg_cnt_r [2];
    logic [CRW-1:0] cr_cnt_r [2];
    assign kill[0] = fault_r[0] | cross_r[1] | ~en_eff;
    assign kill[1] = fault_r[1] | cross_r[0] | ~en_eff;
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_i || !power_ready) begin
                fault_r[i] <= 1'b0;
                cross_r[i] <= 1'b0;
                cr_cnt_r[i] <= '0;
            end else begin
                if (rail_s[i].ov || rail_s[i].uv || rail_s[i].oc) begin
                    fault_r[i] <= 1'b1;
                end
                if (fault_r[i] && !cross_r[i]) begin
                    if (cr_cnt_r[i] == CRW'(drs_pkg::CROSS_DELAY_CYC - 1)) begin
                        cross_r[i] <= 1'b1;
                    end else begin
                        cr_cnt_r[i] <= cr_cnt_r[i] + 1'b1;
                    end
                end
            end
        end
    end
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_i || kill[i] || st_r != drs_pkg::ST_RUN || !rail_s[i].above_pg) begin
                good_r[i] <= 1'b0;
                pg_cnt_r[i] <= '0;
            end else if (pg_cnt_r[i] == PGW'(PG_CYC - 1)) begin
                good_r[i] <= 1'b1;
            end else begin
                pg_cnt_r[i] <= pg_cnt_r[i] + 1'b1;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ccm_o <= 1'b1;
            pg_thresh_mv_o <= 12'h000;
        end else begin
            ccm_o <= (st_r != drs_pkg::ST_RUN) | ~svi_run_r | vid_fly_change_pend_r | ~(&at_tgt);
            pg_thresh_mv_o <= drs_pkg::boot_mv(boot_code_r) - drs_pkg::PG_OFFSET_MV;
        end
    end
    assign core_ref_o = ref_w[0];
    assign nb_ref_o = ref_w[1];
    assign core_switch_o = switch_r[0];
    assign nb_switch_o = switch_r[1];
    assign core_good_o = good_r[0];
    assign nb_good_o = good_r[1];
    assign svi_run_o = svi_run_r;

    // ****************************************
    // wishbone slave
    // ****************************************
    logic wb_req;
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_en_r <= drs_pkg::CTRL_EN_RST;
        end else begin
            wb_ack_o <= wb_req;
            // a write lands at the edge where the master sees ack
            if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == drs_pkg::REG_CTRL && wb_sel_i[0]) begin
                ctrl_en_r <= wb_dat_i[0];
            end
            unique case (wb_adr_i)
                drs_pkg::REG_CTRL: wb_dat_o <= {31'h0, ctrl_en_r};
                drs_pkg::REG_STATUS: wb_dat_o <= {17'h0, cross_r, vid_fly_change_pend_r, svi_run_r, order_err_r,
                    fault_r, good_r, boot_valid_r, boot_code_r, st_r};
                drs_pkg::REG_REF: wb_dat_o <= {4'h0, ref_w[1], 4'h0, ref_w[0]};
                drs_pkg::REG_THRESH: wb_dat_o <= {20'h0, pg_thresh_mv_o};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    localparam int CROSS_MAX = 502;
    sequence s_start;
        st_r == drs_pkg::ST_WAIT_EN && start_ok && power_ready;
    endsequence
    a_ready_supplies: assert property ((st_r != drs_pkg::ST_OFF) |-> $past(power_ready))
        else $error("active without supplies");
    a_start_enable: assert property (s_start |=> st_r == drs_pkg::ST_SOFT)
        else $error("no soft-start on enable");
    a_down_loss: assert property (!power_ready |=> st_r == drs_pkg::ST_OFF && !boot_valid_r)
        else $error("no power-down");
    a_latch_kept: assert property (fault_r[0] && power_ready |=> fault_r[0])
        else $error("fault latch lost");
    a_boot_sample: assert property (s_start |=> boot_code_r == $past(boot_pins))
        else $error("boot code wrong");
    a_telem_idle: assert property (!svi_run_r |=> telemetry_line_o)
        else $error("telemetry not high");
    a_good_enable: assert property (!en_eff |=> !core_good_o && !nb_good_o)
        else $error("good kept after enable loss");
    a_cross_delay: assert property ($rose(fault_r[0]) && power_ready ##1 power_ready [*1]
        |-> ##[1:CROSS_MAX] !nb_good_o)
        else $error("cross rail good not dropped");
    a_switch_stop: assert property (st_r == drs_pkg::ST_SHUT && nb_s.below_off |=> !nb_switch_o)
        else $error("switching not stopped");
endmodule

// ### core/drs_sync.sv
`timescale 1ns/100ps
module drs_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// ### include/drs_pkg.sv
package drs_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int SS_SLEW_UV_PER_US = 3000;
    localparam int VID_FLY_CHANGE_SLEW_UV_PER_US = 12500;
    localparam int SS_STEP_CYC = CLK_MHZ * 1000 / SS_SLEW_UV_PER_US;
    localparam int VID_FLY_CHANGE_STEP_CYC = CLK_MHZ * 1000 / VID_FLY_CHANGE_SLEW_UV_PER_US;
    localparam int PG_DELAY_US = 100;
    localparam int PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
    localparam int CROSS_DELAY_US = 5;
    localparam int CROSS_DELAY_CYC = CROSS_DELAY_US * CLK_MHZ;
    localparam int SVI_READY_MS = 2;
    localparam int SVI_READY_CYC = SVI_READY_MS * 1000 * CLK_MHZ;
    // ****************************************
    // voltages in mV
    // ****************************************
    localparam logic [11:0] BOOT_MV_00 = 12'h44C;
    localparam logic [11:0] BOOT_MV_01 = 12'h3E8;
    localparam logic [11:0] BOOT_MV_10 = 12'h384;
    localparam logic [11:0] BOOT_MV_11 = 12'h320;
    localparam logic [11:0] PG_OFFSET_MV = 12'h12C;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_REF = 8'h08;
    localparam logic [7:0] REG_THRESH = 8'h0C;
    localparam logic CTRL_EN_RST = 1'b1;

    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_WAIT_EN = 3'h1,
        ST_SOFT = 3'h2,
        ST_RUN = 3'h3,
        ST_SHUT = 3'h4
    } drs_state_t;

    // one rail's comparator and protection outputs
    typedef struct packed {
        logic above_pg;
        logic below_off;
        logic ov;
        logic uv;
        logic oc;
    } drs_rail_t;

    function automatic logic [11:0] boot_mv(input logic [1:0] code);
        unique case (code)
            2'h0: boot_mv = BOOT_MV_00;
            2'h1: boot_mv = BOOT_MV_01;
            2'h2: boot_mv = BOOT_MV_10;
            2'h3: boot_mv = BOOT_MV_11;
        endcase
    endfunction
endpackage

// ### verification/drs_far_model.sv
`timescale 1ns/100ps
// ****************************************
// rail sense model
// ****************************************
module drs_far_model (
    input wire logic clk_i,
    input wire logic [11:0] core_ref_i,
    input wire logic [11:0] nb_ref_i,
    input wire logic [11:0] thresh_i,
    input wire logic core_ov_i,
    output drs_pkg::drs_rail_t core_rail_o,
    output drs_pkg::drs_rail_t nb_rail_o
);
    // output lags the reference by a cycle, as a real filter would
    logic [11:0] core_sense_r = 12'h000;
    logic [11:0] nb_sense_r = 12'h000;
    always_ff @(posedge clk_i) begin
        core_sense_r <= core_ref_i;
        nb_sense_r <= nb_ref_i;
    end
    assign core_rail_o = {core_sense_r >= thresh_i, core_sense_r < 12'h0C8, core_ov_i, 2'h0};
    assign nb_rail_o = {nb_sense_r >= thresh_i, nb_sense_r < 12'h0C8, 3'h0};
endmodule

// ### verification/drs_seq_tb_top.sv
`timescale 1ns/100ps
module drs_seq_tb_top;
    // ****************************************
    // stimulus and bookkeeping
    // ****************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ctrl_ok = 1'b0, drv_ok = 1'b0, en_hi = 1'b0, pok = 1'b0, serial_vid_clock = 1'b0, serial_vid_line = 1'b0;
    logic cmd_valid = 1'b0, tdat = 1'b0, core_ov = 1'b0;
    logic [1:0] cmd_sel = 2'h0;
    logic [11:0] cmd_mv = 12'h000;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    drs_pkg::drs_rail_t core_rail, nb_rail;
    logic [11:0] core_ref, nb_ref, thresh, boot, tgt;
    logic core_sw, nb_sw, core_good, nb_good, continuous_conduction, svi_run, telem, vid_fly_change_done, ack;
    logic [1:0] code;
    logic [63:0] rnote;
    logic [63:0] rq[$];
    int err_count = 0;
    int n_checks = 0;
    int seed = 64870;
    int n;

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) tdat <= 1'($random(seed));

    drs_seq #(.PG_CYC(20), .SVI_CYC(50)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ctrl_supply_ok_i(ctrl_ok), .driver_supply_ok_i(drv_ok),
        .enable_hi_i(en_hi), .core_rail_i(core_rail), .nb_rail_i(nb_rail), .platform_ok_i(pok),
        .serial_vid_clock_i(serial_vid_clock), .serial_vid_line_i(serial_vid_line), .cmd_valid_i(cmd_valid),
        .cmd_core_i(cmd_sel[1]), .cmd_nb_i(cmd_sel[0]), .cmd_target_mv_i(cmd_mv), .telem_data_i(tdat),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .core_ref_o(core_ref), .nb_ref_o(nb_ref),
        .core_switch_o(core_sw), .nb_switch_o(nb_sw), .core_good_o(core_good), .nb_good_o(nb_good),
        .ccm_o(continuous_conduction), .svi_run_o(svi_run), .telemetry_line_o(telem), .vid_fly_change_done_o(vid_fly_change_done),
        .pg_thresh_mv_o(thresh)
    );

    drs_far_model i_far (
        .clk_i(clk_i), .core_ref_i(core_ref), .nb_ref_i(nb_ref), .thresh_i(thresh),
        .core_ov_i(core_ov), .core_rail_o(core_rail), .nb_rail_o(nb_rail)
    );

    // ****************************************
    // checking
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // read data is judged at the edge where the master sees ack
    always @(posedge clk_i) begin
        if (ack === 1'b1 && cyc && !we) begin
            rnote = rq.pop_front();
            chk("wb_read", rnote[63:32], rdat & rnote[31:0]);
        end
    end

    // expected read data noted before the request goes out
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        if (!w) rq.push_back({d & m, m});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            #1;
        end while (ack !== 1'b1);
        @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    initial begin
        repeat (90000) @(posedge clk_i);
        err_count++;
        stop_test();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("telemetry", 32'h1, telem);
        chk("goods", 32'h0, {core_good, nb_good});
        chk("ccm", 32'h1, continuous_conduction);
        @(posedge clk_i);
        wb(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF);
        wb(1'b0, drs_pkg::REG_CTRL, 32'h1, 32'h1);
        ctrl_ok <= 1'b1;
        repeat (10) @(posedge clk_i);
        wb(1'b0, drs_pkg::REG_STATUS, 32'h0, 32'h7);
        drv_ok <= 1'b1;
        repeat (10) @(posedge clk_i);
        wb(1'b0, drs_pkg::REG_STATUS, 32'h1, 32'h7);
        code = 2'h2 | 2'($random(seed));
        boot = code[0] ? drs_pkg::BOOT_MV_11 : drs_pkg::BOOT_MV_10;
        serial_vid_clock <= code[1];
        serial_vid_line <= code[0];
        @(posedge clk_i);
        en_hi <= 1'b1;
        repeat (8) @(posedge clk_i);
        serial_vid_clock <= ~code[1];
        serial_vid_line <= ~code[0];
        wb(1'b0, drs_pkg::REG_STATUS, {26'h0, 1'b1, code, 3'h2}, 32'h3F);
        for (n = 0; n < 40000 && core_ref !== 12'h064; n++) @(posedge clk_i);
        repeat (330) @(posedge clk_i);
        chk("ss_slew", 32'h1, core_ref >= 12'h06D && core_ref <= 12'h06F);
        chk("goods_soft", 32'h0, {core_good, nb_good});
        for (n = 0; n < 40000 && core_ref !== boot; n++) @(posedge clk_i);
        chk("refs_boot", {boot, boot}, {core_ref, nb_ref});
        for (n = 0; n < 200 && {core_good, nb_good} !== 2'h3; n++) @(posedge clk_i);
        chk("goods_up", 32'h3, {core_good, nb_good});
        chk("pg_thresh", boot - drs_pkg::PG_OFFSET_MV, thresh);
        chk("svi_idle", 32'h1, {svi_run, telem});
        pok <= 1'b1;
        for (n = 0; n < 10 && svi_run !== 1'b1; n++) @(posedge clk_i);
        chk("svi_run", 32'h1, svi_run);
        tgt = boot + 12'($random(seed) & 63) + 12'h001;
        cmd_mv <= tgt;
        cmd_sel <= 2'h3;
        cmd_valid <= 1'b1;
        @(posedge clk_i);
        cmd_valid <= 1'b0;
        for (n = 0; n < 3000 && vid_fly_change_done !== 1'b1; n++) @(posedge clk_i);
        chk("vid_fly_change_done", 32'h1, vid_fly_change_done);
        chk("fly_done", {tgt, tgt}, {core_ref, nb_ref});
        pok <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("svi_stop", 32'h1, {svi_run, telem});
        cmd_valid <= 1'b1;
        @(posedge clk_i);
        cmd_valid <= 1'b0;
        for (n = 0; n < 3000 && core_ref !== boot; n++) @(posedge clk_i);
        repeat (200) @(posedge clk_i);
        chk("back_boot", {boot, boot}, {core_ref, nb_ref});
        core_ov <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("own_good", 32'h1, {core_good, nb_good});
        repeat (400) @(posedge clk_i);
        chk("cross_wait", 32'h1, nb_good);
        repeat (200) @(posedge clk_i);
        chk("cross_drop", 32'h0, nb_good);
        core_ov <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk("latched", 32'h0, core_good);
        wb(1'b0, drs_pkg::REG_STATUS, 32'h100, 32'h300);
        wb(1'b1, drs_pkg::REG_CTRL, 32'h0, 32'h0);
        for (n = 0; n < 40000 && core_ref !== 12'h1F4; n++) @(posedge clk_i);
        repeat (330) @(posedge clk_i);
        chk("sd_slew", 32'h1, core_ref >= 12'h1E9 && core_ref <= 12'h1EB);
        chk("sd_mode", 32'h3, {continuous_conduction, core_sw});
        for (n = 0; n < 20000 && {core_sw, nb_sw} !== 2'h0; n++) @(posedge clk_i);
        chk("off_level", 32'h1, core_ref <= 12'h0C8 && nb_ref <= 12'h0C8);
        ctrl_ok <= 1'b0;
        repeat (10) @(posedge clk_i);
        wb(1'b0, drs_pkg::REG_STATUS, 32'h0, 32'h327);
        stop_test();
    end
endmodule
